//--- design/hss_pkg.sv
// Overview of operation
// - steps two and three drive at the low search speed, 1 to 500000 pps, default 4000.
// - the low speed is capped at 125000 pps at resolution 1, 250000 at 2, else 500000.
// - step four moves by the signed offset, default 100.
// - the offset sign alone picks the step four direction, positive meaning plus.
// - the offset is scaled by the pulse scale ratio, range +-2147483646 at ratio one.
// - the chosen sensor source is watched in steps one and two only.
// - the sensor source is home input or limit inputs, home by default.
// - with limits chosen, the limit of the current step direction stops the step.
// - each of the four steps has its own enable, all off by default.
// - a disabled step is skipped; an enabled step runs in its own direction.
// - with position clear on, by default, both counters zero at normal completion.
// - home active level is selectable, low by default; the step stops when active.
// - the index input has a selectable active level, low by default; step three stops on it.
`default_nettype none

package hss_pkg;

   // ****************************************************
   // clock and speed ranges
   // ****************************************************
   localparam int unsigned CLK_HZ   = 250_000_000;
   localparam int          SPD_W    = 19;
   localparam int          ACC_W    = 28;
   localparam logic [SPD_W-1:0] SPD_MAX_RES1  = 19'h1E848; // 125000 pps
   localparam logic [SPD_W-1:0] SPD_MAX_RES2  = 19'h3D090; // 250000 pps
   localparam logic [SPD_W-1:0] SPD_MAX_OTHER = 19'h7A120; // 500000 pps

   // ****************************************************
   // register offsets (byte addresses)
   // ****************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_MODE   = 8'h04;
   localparam logic [7:0] OFS_LOWSPD = 8'h08;
   localparam logic [7:0] OFS_OFFSET = 8'h0C;
   localparam logic [7:0] OFS_FAST   = 8'h10;
   localparam logic [7:0] OFS_SCALE  = 8'h14;
   localparam logic [7:0] OFS_RES    = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_LPOS   = 8'h20;
   localparam logic [7:0] OFS_RPOS   = 8'h24;

   // ****************************************************
   // field positions
   // ****************************************************
   localparam int CTRL_START  = 0;
   localparam int CTRL_STOP   = 1;
   localparam int MODE_SRC    = 0;  // 0 home, 1 limits
   localparam int MODE_HLVL   = 1;  // 1 active high
   localparam int MODE_ZLVL   = 2;
   localparam int MODE_EN0    = 3;  // bits 6:3 step enables
   localparam int MODE_DIR0   = 7;  // bits 9:7 step 1..3 direction, 1 is plus
   localparam int MODE_PCLR   = 10;

   // ****************************************************
   // reset values
   // ****************************************************
   localparam logic [10:0]      MODE_RST   = 11'h600; // step3 plus, clear on
   localparam logic [SPD_W-1:0] LOWSPD_RST = 19'h00FA0; // 4000 pps
   localparam logic [31:0]      OFFSET_RST = 32'h00000064; // 100 pulses
   localparam logic [SPD_W-1:0] FAST_RST   = 19'h02710; // 10000 pps
   localparam logic [15:0]      SCALE_RST  = 16'h0001;
   localparam logic [7:0]       RES_RST    = 8'h01;

   typedef enum logic [2:0] {PH_IDLE, PH_STEP1, PH_STEP2, PH_STEP3, PH_STEP4, PH_FINISH}
      hss_phase_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } hss_regreq_s;

   typedef struct packed {
      logic home;
      logic lim_pos;
      logic lim_neg;
      logic index;
   } hss_sense_s;

   // highest legal low speed for a microstep resolution
   function automatic logic [SPD_W-1:0] hss_low_max(input logic [7:0] res);
      if (res == 8'h01)
         return SPD_MAX_RES1;
      else if (res == 8'h02)
         return SPD_MAX_RES2;
      else
         return SPD_MAX_OTHER;
   endfunction

   // low speed held inside 1 .. limit
   function automatic logic [SPD_W-1:0] hss_low_eff(input logic [SPD_W-1:0] spd,
                                                    input logic [7:0] res);
      logic [SPD_W-1:0] mx;
      mx = hss_low_max(res);
      if (spd == '0)
         return 19'h00001;
      else if (spd > mx)
         return mx;
      else
         return spd;
   endfunction

endpackage

`default_nettype wire

//--- design/hss_rate_gen.sv
`default_nettype none

// ****************************************************
// pulse rate generator: one tick per 1/speed seconds
// ****************************************************
module hss_rate_gen #(
   parameter int unsigned CLK_HZ = hss_pkg::CLK_HZ
) (
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_b_i,
   input  wire logic                       ce_i,
   input  wire logic                       run_i,
   input  wire logic [hss_pkg::SPD_W-1:0]  speed_i,
   output logic                            tick_o
);

   typedef struct packed {
      logic [hss_pkg::ACC_W-1:0] acc;
      logic                      tick;
   } hss_gen_s;

   hss_gen_s gen_reg;
   hss_gen_s gen_next;
   logic [hss_pkg::ACC_W:0] sum;

   // phase accumulator; speed is far below the clock so one tick per cycle at most
   always_comb
   begin
      gen_next = gen_reg;
      sum = {1'b0, gen_reg.acc} + {{(hss_pkg::ACC_W+1-hss_pkg::SPD_W){1'b0}}, speed_i};
      gen_next.tick = 1'b0;
      if (!run_i)
      begin
         gen_next.acc = '0;  // restart phase so each search starts a full period
      end
      else if (sum >= (hss_pkg::ACC_W+1)'(CLK_HZ))
      begin
         gen_next.acc  = hss_pkg::ACC_W'(sum - (hss_pkg::ACC_W+1)'(CLK_HZ));
         gen_next.tick = 1'b1;
      end
      else
      begin
         gen_next.acc = sum[hss_pkg::ACC_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         gen_reg <= '0;
      else if (ce_i)
         gen_reg <= gen_next;
   end

   assign tick_o = gen_reg.tick;

endmodule

`default_nettype wire

//--- design/hss_sequencer.sv
// The address map and the address-and-strobe port were chosen for this implementation.
`default_nettype none

module hss_sequencer (
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_b_i,
   input  wire logic                 ce_i,
   input  wire hss_pkg::hss_regreq_s reg_req_i,
   output logic [31:0]               reg_rdata_o,
   input  wire hss_pkg::hss_sense_s  sense_i,
   input  wire logic                 enc_up_i,
   input  wire logic                 enc_dn_i,
   output logic                      pulse_o,
   output logic                      dir_o,
   output logic                      busy_o
);

   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      hss_pkg::hss_phase_e          ph;
      logic [10:0]                  mode;
      logic [hss_pkg::SPD_W-1:0]    low_spd;
      logic [31:0]                  offset;
      logic [hss_pkg::SPD_W-1:0]    fast_spd;
      logic [15:0]                  scl_num;
      logic [15:0]                  scl_den;
      logic [7:0]                   res;
      hss_pkg::hss_sense_s          sy1;
      hss_pkg::hss_sense_s          sy2;
      logic                         dir;
      logic                         pls;
      logic                         done;
      logic                         abort;
      logic [31:0]                  lpos;
      logic [31:0]                  rpos;
      logic [47:0]                  moved;
      logic [47:0]                  target;
      logic [31:0]                  rdata;
   } hss_seq_s;

   hss_seq_s seq_reg;
   hss_seq_s seq_next;

   logic                      tick;
   logic                      drive;
   logic [hss_pkg::SPD_W-1:0] speed;
   logic [hss_pkg::SPD_W-1:0] low_eff;
   logic                      home_act;
   logic                      lim_act;
   logic                      sens_act;
   logic                      idx_act;
   logic [31:0]               off_abs;
   logic                      wr_ctrl;

   // first enabled step after a given step number, else finish
   function automatic hss_pkg::hss_phase_e next_step(input int from, input logic [3:0] en);
      hss_pkg::hss_phase_e r;
      r = hss_pkg::PH_FINISH;
      for (int k = 3; k >= 0; k--)
      begin
         if (k >= from && en[k])
            r = hss_pkg::hss_phase_e'(k + 1);
      end
      return r;
   endfunction

   // ****************************************************
   // sensors and speed
   // ****************************************************
   // level compare makes the active level selectable
   assign home_act = (seq_reg.sy2.home == seq_reg.mode[hss_pkg::MODE_HLVL]);
   assign idx_act  = (seq_reg.sy2.index == seq_reg.mode[hss_pkg::MODE_ZLVL]);
   assign lim_act  = seq_reg.dir ? seq_reg.sy2.lim_pos : seq_reg.sy2.lim_neg;
   assign sens_act = seq_reg.mode[hss_pkg::MODE_SRC] ? lim_act : home_act;
   assign low_eff  = hss_pkg::hss_low_eff(seq_reg.low_spd, seq_reg.res);
   assign speed    = (seq_reg.ph == hss_pkg::PH_STEP2 || seq_reg.ph == hss_pkg::PH_STEP3)
                     ? low_eff : seq_reg.fast_spd;
   assign drive    = (seq_reg.ph >= hss_pkg::PH_STEP1) && (seq_reg.ph <= hss_pkg::PH_STEP4);
   assign off_abs  = seq_reg.offset[31] ? 32'(-seq_reg.offset) : seq_reg.offset;
   assign wr_ctrl  = reg_req_i.wr && (reg_req_i.addr == hss_pkg::OFS_CTRL);

   hss_rate_gen u_rate (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .ce_i      (ce_i),
      .run_i     (drive),
      .speed_i   (speed),
      .tick_o    (tick)
   );

   // ****************************************************
   // next state
   // ****************************************************
   always_comb
   begin
      seq_next = seq_reg;
      seq_next.sy1 = sense_i;
      seq_next.sy2 = seq_reg.sy1;
      seq_next.pls = 1'b0;
      seq_next.rdata = '0;
      // real position follows the encoder count
      if (enc_up_i && !enc_dn_i)
         seq_next.rpos = seq_reg.rpos + 32'h00000001;
      else if (enc_dn_i && !enc_up_i)
         seq_next.rpos = seq_reg.rpos - 32'h00000001;

      // register writes; settings are taken even while a search runs
      if (reg_req_i.wr)
      begin
         case (reg_req_i.addr)
            hss_pkg::OFS_MODE:   seq_next.mode = reg_req_i.wdata[10:0];
            hss_pkg::OFS_LOWSPD: seq_next.low_spd = reg_req_i.wdata[hss_pkg::SPD_W-1:0];
            hss_pkg::OFS_OFFSET: seq_next.offset = reg_req_i.wdata;
            hss_pkg::OFS_FAST:   seq_next.fast_spd = reg_req_i.wdata[hss_pkg::SPD_W-1:0];
            hss_pkg::OFS_SCALE:
            begin
               seq_next.scl_num = reg_req_i.wdata[15:0];
               seq_next.scl_den = reg_req_i.wdata[31:16];
            end
            hss_pkg::OFS_RES:    seq_next.res = reg_req_i.wdata[7:0];
            default:             seq_next.res = seq_reg.res;
         endcase
      end

      // sequence
      case (seq_reg.ph)
         hss_pkg::PH_IDLE, hss_pkg::PH_FINISH:
         begin
            if (seq_reg.ph == hss_pkg::PH_FINISH)
            begin
               seq_next.ph = hss_pkg::PH_IDLE;
               seq_next.done = 1'b1;
               if (seq_reg.mode[hss_pkg::MODE_PCLR])
               begin
                  seq_next.lpos = '0;
                  seq_next.rpos = '0;
               end
            end
            else if (wr_ctrl && reg_req_i.wdata[hss_pkg::CTRL_START])
            begin
               seq_next.done  = 1'b0;
               seq_next.abort = 1'b0;
               // scaled offset: drive pulses until moved, den per pulse, reaches |offset|*num
               seq_next.target = 48'(off_abs) * 48'(seq_reg.scl_num);
               seq_next.moved  = '0;
               seq_next.ph = next_step(0, seq_reg.mode[hss_pkg::MODE_EN0 +: 4]);
               seq_next.dir = seq_reg.mode[hss_pkg::MODE_DIR0];
            end
         end
         hss_pkg::PH_STEP1, hss_pkg::PH_STEP2:
         begin
            // sensor checked before each pulse, so an active sensor stops at once
            if (sens_act)
            begin
               seq_next.ph = next_step(seq_reg.ph == hss_pkg::PH_STEP1 ? 1 : 2,
                                       seq_reg.mode[hss_pkg::MODE_EN0 +: 4]);
               seq_next.dir = seq_reg.mode[hss_pkg::MODE_DIR0 + 1];
               if (seq_reg.ph == hss_pkg::PH_STEP2 || !seq_reg.mode[hss_pkg::MODE_EN0 + 1])
                  seq_next.dir = seq_reg.mode[hss_pkg::MODE_DIR0 + 2];
            end
            else if (tick)
               seq_next.pls = 1'b1;
         end
         hss_pkg::PH_STEP3:
         begin
            if (idx_act)
            begin
               seq_next.ph = next_step(3, seq_reg.mode[hss_pkg::MODE_EN0 +: 4]);
               seq_next.dir = ~seq_reg.offset[31];
            end
            else if (tick)
               seq_next.pls = 1'b1;
         end
         hss_pkg::PH_STEP4:
         begin
            seq_next.dir = ~seq_reg.offset[31];
            if (seq_reg.moved >= seq_reg.target)
               seq_next.ph = hss_pkg::PH_FINISH;
            else if (tick)
            begin
               seq_next.pls = 1'b1;
               seq_next.moved = seq_reg.moved + {32'h00000000, seq_reg.scl_den};
            end
         end
         default:
            seq_next.ph = hss_pkg::PH_IDLE;
      endcase

      // stop ends the search without the position clear
      if (drive && wr_ctrl && reg_req_i.wdata[hss_pkg::CTRL_STOP])
      begin
         seq_next.ph = hss_pkg::PH_IDLE;
         seq_next.abort = 1'b1;
         seq_next.pls = 1'b0;
      end
      // step 1 direction taken on entry from idle; later steps set it on the way in
      if (seq_reg.ph == hss_pkg::PH_IDLE && seq_next.ph != hss_pkg::PH_IDLE)
      begin
         if (seq_next.ph == hss_pkg::PH_STEP2)
            seq_next.dir = seq_reg.mode[hss_pkg::MODE_DIR0 + 1];
         else if (seq_next.ph == hss_pkg::PH_STEP3)
            seq_next.dir = seq_reg.mode[hss_pkg::MODE_DIR0 + 2];
         else if (seq_next.ph == hss_pkg::PH_STEP4)
            seq_next.dir = ~seq_reg.offset[31];
      end
      // logical position follows issued pulses
      if (seq_next.pls)
         seq_next.lpos = seq_next.dir ? seq_reg.lpos + 32'h00000001
                                      : seq_reg.lpos - 32'h00000001;

      // reads answer one cycle later; unmapped reads give zero
      if (reg_req_i.rd)
      begin
         case (reg_req_i.addr)
            hss_pkg::OFS_MODE:   seq_next.rdata = {21'h000000, seq_reg.mode};
            hss_pkg::OFS_LOWSPD: seq_next.rdata = {13'h0000, seq_reg.low_spd};
            hss_pkg::OFS_OFFSET: seq_next.rdata = seq_reg.offset;
            hss_pkg::OFS_FAST:   seq_next.rdata = {13'h0000, seq_reg.fast_spd};
            hss_pkg::OFS_SCALE:  seq_next.rdata = {seq_reg.scl_den, seq_reg.scl_num};
            hss_pkg::OFS_RES:    seq_next.rdata = {24'h000000, seq_reg.res};
            hss_pkg::OFS_STATUS: seq_next.rdata = {26'h0000000, seq_reg.abort, seq_reg.done,
                                                   seq_reg.ph, drive};
            hss_pkg::OFS_LPOS:   seq_next.rdata = seq_reg.lpos;
            hss_pkg::OFS_RPOS:   seq_next.rdata = seq_reg.rpos;
            default:             seq_next.rdata = '0;
         endcase
      end
   end

   // registers; clock enable low freezes everything, a strobe in that cycle is lost
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         seq_reg          <= '0;
         seq_reg.ph       <= hss_pkg::PH_IDLE;
         seq_reg.mode     <= hss_pkg::MODE_RST;
         seq_reg.low_spd  <= hss_pkg::LOWSPD_RST;
         seq_reg.offset   <= hss_pkg::OFFSET_RST;
         seq_reg.fast_spd <= hss_pkg::FAST_RST;
         seq_reg.scl_num  <= hss_pkg::SCALE_RST;
         seq_reg.scl_den  <= hss_pkg::SCALE_RST;
         seq_reg.res      <= hss_pkg::RES_RST;
      end
      else if (ce_i)
         seq_reg <= seq_next;
   end

   assign reg_rdata_o = seq_reg.rdata;
   assign pulse_o     = seq_reg.pls;
   assign dir_o       = seq_reg.dir;
   assign busy_o      = drive;

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   a_low_speed_used: assert property ((seq_reg.ph == hss_pkg::PH_STEP2
      || seq_reg.ph == hss_pkg::PH_STEP3) |-> speed == low_eff)
      else $error("low search speed not applied");
   a_low_speed_cap: assert property (speed != '0 && low_eff <= hss_pkg::hss_low_max(seq_reg.res)
      && (seq_reg.res != 8'h01 || low_eff <= hss_pkg::SPD_MAX_RES1))
      else $error("low speed above resolution limit");
   a_offset_stop: assert property (ce_i && seq_reg.ph == hss_pkg::PH_STEP4
      && seq_reg.moved >= seq_reg.target && !wr_ctrl |=> seq_reg.ph == hss_pkg::PH_FINISH)
      else $error("offset move overran");
   a_offset_dir: assert property (ce_i && seq_reg.ph == hss_pkg::PH_STEP4
      |=> !seq_reg.pls || seq_reg.dir == ~$past(seq_reg.offset[31]))
      else $error("offset pulse in wrong direction");
   a_scale_count: assert property (ce_i && seq_reg.ph == hss_pkg::PH_STEP4 && tick
      && seq_reg.moved < seq_reg.target && !wr_ctrl
      |=> seq_reg.pls && seq_reg.moved == $past(seq_reg.moved) + {32'h0, $past(seq_reg.scl_den)})
      else $error("scaled offset count wrong");
   a_sensor_stop: assert property (ce_i && seq_reg.ph == hss_pkg::PH_STEP1 && sens_act
      |=> seq_reg.ph != hss_pkg::PH_STEP1 && !seq_reg.pls)
      else $error("step one ran past active sensor");
   a_limit_select: assert property (ce_i && seq_reg.ph == hss_pkg::PH_STEP1
      && seq_reg.mode[hss_pkg::MODE_SRC] && !seq_reg.dir && seq_reg.sy2.lim_neg
      |=> seq_reg.ph != hss_pkg::PH_STEP1 && !seq_reg.pls)
      else $error("wrong limit watched");
   a_skip_all: assert property (ce_i && seq_reg.ph == hss_pkg::PH_IDLE && wr_ctrl
      && reg_req_i.wdata[0] && seq_reg.mode[6:3] == 4'h0 |=> seq_reg.ph == hss_pkg::PH_FINISH)
      else $error("disabled steps not skipped");
   a_pos_clear: assert property (ce_i && seq_reg.ph == hss_pkg::PH_FINISH
      && seq_reg.mode[hss_pkg::MODE_PCLR] |=> seq_reg.lpos == '0 && seq_reg.rpos == '0
      && seq_reg.done)
      else $error("positions not cleared at completion");
   a_index_stop: assert property (ce_i && seq_reg.ph == hss_pkg::PH_STEP3 && idx_act
      && !wr_ctrl |=> seq_reg.ph > hss_pkg::PH_STEP3)
      else $error("index did not end step three");
   a_step_order: assert property (ce_i && drive |=> seq_reg.ph == hss_pkg::PH_IDLE
      || seq_reg.ph >= $past(seq_reg.ph))
      else $error("steps ran out of order");

   c_full_search: cover property (seq_reg.ph == hss_pkg::PH_STEP4 ##1 seq_reg.ph == hss_pkg::PH_FINISH);
   c_index_found: cover property (seq_reg.ph == hss_pkg::PH_STEP3 && idx_act);
   c_stopped:     cover property (drive ##1 seq_reg.abort);

endmodule

`default_nettype wire

//--- testbench/hss_sense_model.sv
`default_nettype none

// ****************************************************
// far side: home switch, limits, index and encoder
// ****************************************************
module hss_sense_model (
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              pulse_i,
   input  wire logic              dir_i,
   input  wire logic              hl_i,
   input  wire logic              zl_i,
   input  wire logic signed [7:0] home_at_i,
   output var hss_pkg::hss_sense_s sense_o,
   output logic                   up_o,
   output logic                   dn_o,
   output logic [15:0]            gap_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic signed [7:0] pos_reg;
   logic [15:0]       cnt_reg;

   // axis follows every drive pulse; gap holds the last pulse spacing in cycles
   always_ff @(posedge clk_i or negedge rst_b_i)
      if (!rst_b_i)
      begin
         pos_reg <= 8'sh00;
         cnt_reg <= 16'h0000;
         gap_o   <= 16'h0000;
      end
      else if (pulse_i)
      begin
         pos_reg <= dir_i ? pos_reg + 8'sh01 : pos_reg - 8'sh01;
         gap_o   <= cnt_reg;
         cnt_reg <= 16'h0001;
      end
      else
         cnt_reg <= cnt_reg + 16'h0001;

   // encoder echoes in the same cycle so the clear never races a late count
   assign up_o = pulse_i & dir_i;
   assign dn_o = pulse_i & ~dir_i;
   // home and index show the chosen active level; the sequencer reads a limit as active high
   assign sense_o = '{home:    (pos_reg >= home_at_i) ~^ hl_i,
                      index:   (pos_reg == 8'sh01) ~^ zl_i,
                      lim_pos: pos_reg >= 8'sh28,
                      lim_neg: pos_reg <= -8'sh02};
endmodule

`default_nettype wire

//--- testbench/testbench.sv
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 sys_clk_i   = 1'b0;
   logic                 rst_b_i     = 1'b0;
   hss_pkg::hss_regreq_s req         = '0;
   hss_pkg::hss_sense_s  sense;
   logic [31:0]          rdata;
   logic [31:0]          seed        = 32'd69285;
   logic signed [31:0]   off;
   logic                 pulse, dir, busy, up, dn, pclr;
   logic                 hl          = 1'b0;
   logic                 ce          = 1'b1;
   logic                 zl          = 1'b0;
   logic signed [7:0]    home_at     = 8'sh03;
   logic [15:0]          gap;
   int                   miscompares = 0;
   int                   compares    = 0;
   int                   cyc         = 0;

   always #2 sys_clk_i = ~sys_clk_i;

   hss_sequencer dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
      .reg_req_i(req), .reg_rdata_o(rdata), .sense_i(sense), .enc_up_i(up), .enc_dn_i(dn),
      .pulse_o(pulse), .dir_o(dir), .busy_o(busy));
   hss_sense_model far_u (.clk_i(sys_clk_i), .rst_b_i(rst_b_i), .pulse_i(pulse),
      .dir_i(dir), .hl_i(hl), .zl_i(zl), .home_at_i(home_at), .sense_o(sense), .up_o(up),
      .dn_o(dn), .gap_o(gap));

   // ****************************************************
   // shared tasks
   // ****************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // low speed period in cycles: capped speed by resolution
   function automatic logic [31:0] low_gap(input logic [7:0] r);
      return hss_pkg::CLK_HZ / (r == 8'h01 ? 125000 : r == 8'h02 ? 250000 : 500000);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk_i);
      req <= '0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk_i);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge sys_clk_i);
      req <= '0;
      #1 check(rdata, exp);
   endtask

   task automatic rst();
      rst_b_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      // fast start speed kept above every legal low speed
      wr(hss_pkg::OFS_FAST, 32'h0007FFFF);
   endtask

   // start a search and wait for the sequencer to go idle, bounded
   task automatic run(input logic [31:0] mode);
      int n;
      n = 0;
      wr(hss_pkg::OFS_MODE, mode);
      wr(hss_pkg::OFS_CTRL, 32'h1);
      do
      begin
         @(posedge sys_clk_i);
         #1 n++;
      end while (busy === 1'b1 && n < 40000);
      rchk(hss_pkg::OFS_STATUS, 32'h10);
   endtask

   task automatic results();
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // hang guard well above the longest expected run
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 100000)
      begin
         miscompares++;
         results();
      end
   end

   // ****************************************************
   // main sequence
   // ****************************************************
   initial
   begin
      rst();
      rchk(hss_pkg::OFS_MODE, 32'h600);
      rchk(hss_pkg::OFS_LOWSPD, 32'd4000);
      rchk(hss_pkg::OFS_OFFSET, 32'd100);
      // a write while the clock enable is low is lost
      @(posedge sys_clk_i) ce <= 1'b0;
      wr(hss_pkg::OFS_OFFSET, 32'h00000005);
      ce <= 1'b1;
      rchk(hss_pkg::OFS_OFFSET, 32'd100);
      // fast home search then offset, zero offset first as a corner
      for (int i = 0; i < 4; i++)
      begin
         repeat (8) seed = lfsr(seed);
         off = (i == 0) ? 32'sh0 : 32'($signed(seed[2:0]));
         home_at = 8'sh01 + 8'(seed[5:4]);
         hl = seed[6];
         pclr = seed[7];
         rst();
         wr(hss_pkg::OFS_OFFSET, off);
         run(32'h0C8 | (32'(hl) << 1) | (32'(pclr) << 10));
         rchk(hss_pkg::OFS_LPOS, pclr ? 32'h0 : 32'(home_at) + off);
         rchk(hss_pkg::OFS_RPOS, pclr ? 32'h0 : 32'(home_at) + off);
      end
      // stop in mid search: back to idle, aborted, not done
      hl = 1'b0;
      home_at = 8'sh7F;
      rst();
      wr(hss_pkg::OFS_MODE, 32'h00000488);
      wr(hss_pkg::OFS_CTRL, 32'h00000001);
      wr(hss_pkg::OFS_CTRL, 32'h00000002);
      rchk(hss_pkg::OFS_STATUS, 32'h20);
      // limit search minus then index plus at low speed, per resolution
      for (int r = 1; r <= 4; r = r * 2)
      begin
         repeat (8) seed = lfsr(seed);
         zl = seed[0];
         rst();
         wr(hss_pkg::OFS_LOWSPD, 32'h0007A120);
         wr(hss_pkg::OFS_RES, 32'(r));
         run(32'h229 | (32'(zl) << 2));
         rchk(hss_pkg::OFS_LPOS, 32'h1);
         check(32'(gap), low_gap(8'(r)));
      end
      results();
   end
endmodule

`default_nettype wire
